// file: rtl/iod_regs.svh
// Register indices, field positions, reset values and fixed addresses
`ifndef IOD_REGS_SVH
`define IOD_REGS_SVH
`define IOD_IDX_LDN          8'h07
`define IOD_IDX_OSC_CFG      8'h24
`define IOD_IDX_CFG_PORT_LO  8'h26
`define IOD_IDX_CFG_PORT_HI  8'h27
`define IOD_IDX_WIN0_HI      8'h60
`define IOD_IDX_WIN3_LO      8'h67
`define IOD_IDX_ACTIVATE     8'h30
`define IOD_IDX_IRQ_ROUTE    8'h70
`define IOD_IDX_IRQ8_POL     8'hF1
`define IOD_IDX_XMODE        8'hF0
`define IOD_LDN_EXT          8'h08
`define IOD_LDN_RUNTIME      8'h0A
`define IOD_OSC_QUAL16_BIT   6
`define IOD_CFG_PORT_LOW     16'h002E
`define IOD_CFG_PORT_HIGH    16'h004E
`define IOD_ROUTE_RESET      8'h00
`define IOD_ROUTE_NONE       4'h0
`define IOD_ROUTE_SMI        4'h2
`define IOD_ADDR_MAX         12'hFFF
`define IOD_ALIGN_1B         0
`define IOD_ALIGN_4B         2
`define IOD_ALIGN_16B        4
`endif

// file: rtl/iod_pkg.sv
// Types shared by the decode and configuration logic
package iod_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  data;
    } iod_io_cycle_t;

    typedef struct packed {
        logic [11:0] base;
        logic        enable;
    } iod_window_t;

    typedef enum logic [0:0] {
        IOD_MODE_1 = 1'b0,
        IOD_MODE_2 = 1'b1
    } iod_ext_mode_t;
endpackage

// file: rtl/iod_window_match.sv
// One chip-select window comparator with per-window alignment
`timescale 1ns/1ps
`default_nettype none
module iod_window_match
    import iod_pkg::*;
#(
    parameter int ALIGN_BITS_M1 = 0,
    parameter int ALIGN_BITS_M2 = 0
) (
    input  wire logic          addr_ok,
    input  wire logic [11:0]   addr,
    input  wire iod_window_t   win,
    input  wire iod_ext_mode_t mode,
    output logic               hit
);
    // Wider masks would start eating into the programmed base itself
    if (ALIGN_BITS_M1 < 0 || ALIGN_BITS_M1 > 4 ||
        ALIGN_BITS_M2 < 0 || ALIGN_BITS_M2 > 4) begin : g_align_check
        $error("window alignment beyond 16 bytes unsupported");
    end

    // Low bits below the alignment are ignored on both sides
    wire [11:0] mask_m1 = 12'hFFF << ALIGN_BITS_M1;
    wire [11:0] mask_m2 = 12'hFFF << ALIGN_BITS_M2;
    wire [11:0] mask    = (mode == IOD_MODE_2) ? mask_m2 : mask_m1;

    assign hit = addr_ok && win.enable &&
                 ((addr & mask) == (win.base & mask));
endmodule
`default_nettype wire

// file: rtl/iod_config_decode.sv
// Configuration port, chip-select window decode and interrupt routing
//
// What this block does
// - Window 0 base at 0x60/0x61, any byte 0x000-0xFFF, both modes.
// - Window 1 base at 0x62/0x63, 4-byte aligned, both modes.
// - Windows 2,3 at 0x64-0x67: 4-byte aligned mode 1, 16-byte mode 2.
// - Index written at config port, data read/written at port plus one.
// - Config port powers up at 0x02E or 0x04E by strap; relocatable.
// - Decode uses A11:A0; oscillator bit 6 also demands A15:A12 zero.
// - Route nibble: 0 none, 1-15 IRQ line, 2 drives SMI; upper reserved.
// - Routed IRQ lines follow the source level, active high; IRQ8 is active low while its polarity bit is set.
// - SMI output is active low while an interrupt is routed there.
// - IRQ8 polarity chosen by bit 0 of index 0xF1 in runtime device.
// - An IRQ line no device selects stays inactive.
`timescale 1ns/1ps
`default_nettype none
`include "iod_regs.svh"
module iod_config_decode
    import iod_pkg::*;
#(
    parameter int NUM_WIN = 4
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          config_port_strap,
    input  wire iod_io_cycle_t io_cycle,
    output logic [7:0]         io_rdata,
    output logic               io_rdata_valid,
    input  wire logic          ext_irq_src,
    output logic [NUM_WIN-1:0] ext_select_window,
    output logic [15:1]        irq_line,
    output logic               system_mgmt_irq_n
);
    // The one-hot select and the window table assume four windows
    if (NUM_WIN != 4) begin : g_num_win_check
        $error("exactly four chip-select windows are supported");
    end

    ////////////////////////////////////////////////////////////////////
    // Strap synchroniser and power-up port placement
    // The strap is a pin; only the second flop is ever read
    logic strap_s1;
    logic strap_s2;
    logic strap_taken;
    always_ff @(posedge clk) begin
        strap_s1 <= config_port_strap;
        strap_s2 <= strap_s1;
    end

    logic [7:0]  index_reg;
    logic [7:0]  ldn;
    logic [7:0]  osc_cfg;
    logic [15:0] cfg_port;
    logic        ext_active;
    logic [7:0]  xmode;
    logic [7:0]  irq8_pol;
    logic [7:0]  primary_interrupt_route;
    logic [7:0]  win_reg [0:7];

    ////////////////////////////////////////////////////////////////////
    // Address qualification
    // Qualification gates every decode, the config port pair included
    wire qual16  = osc_cfg[`IOD_OSC_QUAL16_BIT];
    wire addr_ok = io_cycle.valid &&
                   (!qual16 || io_cycle.addr[15:12] == 4'h0);
    wire [11:0] a12 = io_cycle.addr[11:0];

    wire idx_hit  = addr_ok && a12 == cfg_port[11:0];
    wire data_hit = addr_ok && a12 == cfg_port[11:0] + 12'h001;
    wire cfg_hit  = idx_hit || data_hit;
    wire wr_idx   = idx_hit && io_cycle.write;
    wire wr_data  = data_hit && io_cycle.write;
    wire global_i = index_reg < `IOD_IDX_ACTIVATE;
    wire on_ext   = ldn == `IOD_LDN_EXT;
    wire on_rt    = ldn == `IOD_LDN_RUNTIME;
    wire win_idx  = index_reg >= `IOD_IDX_WIN0_HI &&
                    index_reg <= `IOD_IDX_WIN3_LO;
    wire [2:0] wsel = index_reg[2:0];

    // Write strobes; device registers need their device selected first
    wire wr_plo   = wr_data && index_reg == `IOD_IDX_CFG_PORT_LO;
    wire wr_phi   = wr_data && index_reg == `IOD_IDX_CFG_PORT_HI;
    wire wr_ldn   = wr_data && index_reg == `IOD_IDX_LDN;
    wire wr_osc   = wr_data && index_reg == `IOD_IDX_OSC_CFG;
    wire wr_act   = wr_data && on_ext && index_reg == `IOD_IDX_ACTIVATE;
    wire wr_xmode = wr_data && on_ext && index_reg == `IOD_IDX_XMODE;
    wire wr_route = wr_data && on_ext && index_reg == `IOD_IDX_IRQ_ROUTE;
    wire wr_pol   = wr_data && on_rt && index_reg == `IOD_IDX_IRQ8_POL;
    wire wr_win   = wr_data && on_ext && win_idx;

    ////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            strap_taken <= 1'b0;
            index_reg   <= 8'h00;
            ldn         <= 8'h00;
            osc_cfg     <= 8'h00;
            cfg_port    <= `IOD_CFG_PORT_LOW;
            ext_active  <= 1'b0;
            xmode       <= 8'h00;
            irq8_pol    <= 8'h00;
            primary_interrupt_route <= `IOD_ROUTE_RESET;
        end else begin
            if (!strap_taken) begin
                // Strap is caught after release, port picked once
                strap_taken <= 1'b1;
                cfg_port    <= strap_s2 ? `IOD_CFG_PORT_HIGH
                                        : `IOD_CFG_PORT_LOW;
            end else if (wr_plo) begin
                // Bit 0 dropped keeps the port pair on a 2-byte boundary
                cfg_port[7:0] <= {io_cycle.data[7:1], 1'b0};
            end else if (wr_phi) begin
                cfg_port[15:8] <= io_cycle.data;
            end
            if (wr_idx)
                index_reg <= io_cycle.data;
            if (wr_ldn)
                ldn <= io_cycle.data;
            if (wr_osc)
                osc_cfg <= io_cycle.data;
            if (wr_act)
                ext_active <= io_cycle.data[0];
            if (wr_xmode)
                xmode <= io_cycle.data;
            if (wr_route)
                primary_interrupt_route <= {4'h0, io_cycle.data[3:0]};
            if (wr_pol)
                irq8_pol <= {7'h00, io_cycle.data[0]};
        end
    end

    // Base registers; no reset needed beyond zero base
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 8; i++)
                win_reg[i] <= 8'h00;
        end else if (wr_win) begin
            win_reg[wsel] <= io_cycle.data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data port readback
    logic [7:0] rd_val;
    always_comb begin
        rd_val = 8'h00;
        if (index_reg == `IOD_IDX_LDN)
            rd_val = ldn;
        else if (index_reg == `IOD_IDX_OSC_CFG)
            rd_val = osc_cfg;
        else if (index_reg == `IOD_IDX_CFG_PORT_LO)
            rd_val = cfg_port[7:0];
        else if (index_reg == `IOD_IDX_CFG_PORT_HI)
            rd_val = cfg_port[15:8];
        else if (!global_i && on_ext && win_idx)
            rd_val = win_reg[wsel];
        else if (on_ext && index_reg == `IOD_IDX_ACTIVATE)
            rd_val = {7'h00, ext_active};
        else if (on_ext && index_reg == `IOD_IDX_XMODE)
            rd_val = xmode;
        else if (on_ext && index_reg == `IOD_IDX_IRQ_ROUTE)
            rd_val = primary_interrupt_route;
        else if (on_rt && index_reg == `IOD_IDX_IRQ8_POL)
            rd_val = irq8_pol;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            io_rdata       <= 8'h00;
            io_rdata_valid <= 1'b0;
        end else begin
            io_rdata_valid <= cfg_hit && !io_cycle.write;
            io_rdata       <= idx_hit ? index_reg : rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Chip-select windows
    iod_ext_mode_t mode;
    assign mode = iod_ext_mode_t'(xmode[0]);
    wire [NUM_WIN-1:0] win_hit;
    localparam int AL_M1 [0:3] = '{`IOD_ALIGN_1B, `IOD_ALIGN_4B,
                                   `IOD_ALIGN_4B, `IOD_ALIGN_4B};
    localparam int AL_M2 [0:3] = '{`IOD_ALIGN_1B, `IOD_ALIGN_4B,
                                   `IOD_ALIGN_16B, `IOD_ALIGN_16B};
    // Config port cycles are masked so an overlapping window stays quiet

    for (genvar w = 0; w < NUM_WIN; w++) begin : g_win
        iod_window_t win;
        assign win.base   = {win_reg[2*w][3:0], win_reg[2*w+1]};
        assign win.enable = ext_active;
        iod_window_match #(
            .ALIGN_BITS_M1 (AL_M1[w]),
            .ALIGN_BITS_M2 (AL_M2[w])
        ) u_match (
            .addr_ok (addr_ok && !cfg_hit),
            .addr    (a12),
            .win     (win),
            .mode    (mode),
            .hit     (win_hit[w])
        );
    end

    // Lowest window wins so only one select is ever asserted
    wire [NUM_WIN-1:0] win_one = win_hit & (~win_hit + 4'h1);
    assign ext_select_window = win_one;

    ////////////////////////////////////////////////////////////////////
    // Interrupt routing
    // Lines the route does not name idle low; there is no separate
    // management disable, so IRQ2 is only free while route is not 2
    wire [3:0] route = primary_interrupt_route[3:0];
    for (genvar n = 1; n < 16; n++) begin : g_irq
        wire sel = ext_active && route == 4'(n);
        if (n == 8) begin : g_pol
            assign irq_line[n] = sel && (ext_irq_src ^ irq8_pol[0]);
        end else begin : g_plain
            assign irq_line[n] = sel && ext_irq_src;
        end
    end
    assign system_mgmt_irq_n = !(ext_active && route == `IOD_ROUTE_SMI
                                 && ext_irq_src);
endmodule
`default_nettype wire

// file: verification/iod_host_model.sv
// Host-side model issuing single-cycle I/O transfers
`timescale 1ns/1ps
`default_nettype none
module iod_host_model
    import iod_pkg::*;
(
    input  wire logic          clk,
    input  wire logic [7:0]    io_rdata,
    input  wire logic          io_rdata_valid,
    output var  iod_io_cycle_t io_cycle
);
    initial io_cycle = '0;
    // Idle bus shows inverted fields so stale values never look valid
    task automatic cyc(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        @(negedge clk);
        io_cycle = '{1'b1, w, a, d};
        @(negedge clk);
        io_cycle = '{1'b0, ~w, ~a, ~d};
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] q);
        cyc(1'b0, a, 8'h00);
        q = io_rdata_valid ? io_rdata : 8'hXX;
    endtask
endmodule
`default_nettype wire

// file: verification/iod_config_decode_assertions.sv
// Port-level checks for the configuration and decode block
`timescale 1ns/1ps
`default_nettype none
module iod_config_decode_assertions
    import iod_pkg::*;
#(
    parameter int NUM_WIN = 4
) (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               config_port_strap,
    input wire iod_io_cycle_t      io_cycle,
    input wire logic [7:0]         io_rdata,
    input wire logic               io_rdata_valid,
    input wire logic               ext_irq_src,
    input wire logic [NUM_WIN-1:0] ext_select_window,
    input wire logic [15:1]        irq_line,
    input wire logic               system_mgmt_irq_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rst_release;
        rst ##1 !rst;
    endsequence
    sel_onehot_a: assert property ($onehot0(ext_select_window))
        else $error("several window selects at once");
    sel_valid_a: assert property (|ext_select_window |-> io_cycle.valid)
        else $error("window select outside a cycle");
    rd_cause_a: assert property (io_rdata_valid |->
        $past(io_cycle.valid && !io_cycle.write))
        else $error("read data without a read");
    irq_onehot_a: assert property ($onehot0(irq_line))
        else $error("more than one interrupt line active");
    irq_src_a: assert property (
        |{irq_line[15:9], irq_line[7:1]} |-> ext_irq_src)
        else $error("interrupt line without source");
    smi_src_a: assert property (!system_mgmt_irq_n |-> ext_irq_src)
        else $error("management interrupt without source");
    smi_excl_a: assert property (!system_mgmt_irq_n |->
        irq_line[15:3] == '0 && !irq_line[1])
        else $error("interrupt line beside management interrupt");
    rst_quiet_a: assert property (disable iff (1'b0) rst |=>
        irq_line == '0 && system_mgmt_irq_n && !io_rdata_valid)
        else $error("outputs active in reset");
    start_idle_a: assert property (disable iff (1'b0)
        s_rst_release |-> ext_select_window == '0 && io_rdata == 8'h00)
        else $error("outputs not idle after reset");
endmodule
bind iod_config_decode iod_config_decode_assertions #(.NUM_WIN(NUM_WIN))
    i_chk (.clk(clk), .rst(rst), .config_port_strap(config_port_strap),
    .io_cycle(io_cycle), .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid), .ext_irq_src(ext_irq_src),
    .ext_select_window(ext_select_window), .irq_line(irq_line),
    .system_mgmt_irq_n(system_mgmt_irq_n));
`default_nettype wire

// file: verification/iod_config_decode_tb_top.sv
// Self-checking bench for the configuration and decode block
`timescale 1ns/1ps
`default_nettype none
module iod_config_decode_tb_top
    import iod_pkg::*;
;
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    logic          strap = 1'b0;
    logic          src = 1'b0;
    iod_io_cycle_t io_cycle;
    logic [7:0]    io_rdata;
    logic          io_rdata_valid;
    logic [3:0]    sel;
    logic [15:1]   irq;
    logic          smi_n;
    logic [15:0]   port;
    logic [14:0]   e;
    logic [7:0]    rv;
    int            n_errors = 0;
    int            tests_run = 0;
    int            cyc_n = 0;
    // Window bases, activation and mode 1 as index/value pairs
    logic [159:0]  tbl = {80'h6003_6101_6203_6304_6403,
                          80'h6520_6603_6734_3001_F000};
    always #2.5 clk = ~clk;
    iod_config_decode #(.NUM_WIN(4)) i_dut (.clk(clk), .rst(rst),
        .config_port_strap(strap), .io_cycle(io_cycle),
        .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .ext_irq_src(src), .ext_select_window(sel), .irq_line(irq),
        .system_mgmt_irq_n(smi_n));
    iod_host_model i_host (.clk(clk), .io_rdata(io_rdata),
        .io_rdata_valid(io_rdata_valid), .io_cycle(io_cycle));
    task automatic test_done;
        if (n_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        tests_run++;
        if (s !== x) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        i_host.cyc(1'b1, port, i);
        i_host.cyc(1'b1, port + 16'h0001, d);
    endtask
    task automatic rreg(input logic [7:0] i, input logic [7:0] x);
        logic [7:0] r;
        i_host.cyc(1'b1, port, i);
        i_host.rd(port + 16'h0001, r);
        chk({8'h00, r}, {8'h00, x});
    endtask
    task automatic hit(input logic [15:0] a, input logic [3:0] x);
        fork
            i_host.cyc(1'b1, a, 8'h00);
            begin
                @(negedge clk);
                #1 chk({12'h000, sel}, {12'h000, x});
            end
        join
    endtask
    task automatic do_reset(input logic s);
        @(negedge clk);
        rst = 1'b1;
        strap = s;
        src = 1'b0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 4000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        do_reset(1'b0);
        port = 16'h002E;
        wreg(8'h07, 8'h08);
        rreg(8'h07, 8'h08);
        rreg(8'h70, 8'h00);
        rreg(8'hA0, 8'h00);
        i_host.rd(port, rv);
        chk({8'h00, rv}, 16'h00A0);
        wreg(8'h26, 8'h61);
        port = 16'h0060;
        rreg(8'h26, 8'h60);
        for (int k = 0; k < 10; k++)
            wreg(tbl[159-16*k -: 8], tbl[151-16*k -: 8]);
        hit(16'h0301, 4'h1);
        hit(16'h0302, 4'h0);
        hit(16'h0307, 4'h2);
        hit(16'h0308, 4'h0);
        hit(16'h0323, 4'h4);
        hit(16'h0324, 4'h0);
        hit(16'h0337, 4'h8);
        hit(16'h1301, 4'h1);
        wreg(8'hF0, 8'h01);
        hit(16'h032F, 4'h4);
        hit(16'h0330, 4'h8);
        hit(16'h0307, 4'h2);
        // Windows 2 and 3 overlap: the lower one alone answers
        wreg(8'h67, 8'h20);
        hit(16'h0325, 4'h4);
        // Window 0 on the data port: the config cycle raises nothing
        wreg(8'h60, 8'h00);
        wreg(8'h61, 8'h61);
        hit(16'h0061, 4'h0);
        wreg(8'h24, 8'h40);
        hit(16'h1301, 4'h0);
        // Index write through an aliased port must be ignored
        i_host.cyc(1'b1, 16'h1060, 8'h07);
        i_host.rd(port + 16'h0001, rv);
        chk({8'h00, rv}, 16'h0040);
        // IRQ2 is masked out of the line check here; route 2 is checked on the management interrupt
        for (int n = 0; n < 16; n++) begin
            e = (n == 0) ? 15'h0000 : 15'h0001 << (n - 1);
            wreg(8'h70, {4'hF, n[3:0]});
            rreg(8'h70, {4'h0, n[3:0]});
            src = 1'b1;
            #1 chk({1'b0, irq & 15'h7FFD}, {1'b0, e & 15'h7FFD});
            chk({15'h0000, smi_n}, {15'h0000, n != 2});
            @(negedge clk);
            src = 1'b0;
            #1 chk({1'b0, irq}, 16'h0000);
        end
        wreg(8'h70, 8'h08);
        wreg(8'h07, 8'h0A);
        wreg(8'hF1, 8'h01);
        #1 chk({1'b0, irq}, 16'h0080);
        @(negedge clk);
        src = 1'b1;
        #1 chk({1'b0, irq}, 16'h0000);
        do_reset(1'b1);
        port = 16'h004E;
        wreg(8'h07, 8'h08);
        rreg(8'h07, 8'h08);
        rreg(8'h70, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
